// ### design/eew_pkg.sv
// Shared constants and types for the protected page write host controller.
// Assumes a single 100 MHz system clock; all times become whole clock counts.
package eew_pkg;
  localparam int CLK_NS = 10; // System clock period
  localparam int ADDR_W = 17; // Full memory address width
  localparam int CMD_ADDR_W = 15; // Command address lines compared by the device
  localparam int OFS_W = 7; // In-page offset width
  localparam int PAGE_BYTES = 128; // Largest page load
  localparam int CMD_LEN = 3; // Bytes in a protection command sequence
  localparam int CNT_W = 5; // Width of the strobe timing counter
  // Strobe times in ns and write period in ms, as printed
  localparam int T_WP_NS = 100; // Write pulse width, least
  localparam int T_WPH_NS = 50; // Write pulse high, least
  localparam int T_AH_NS = 50; // Address hold after strobe fall, least
  localparam int T_ACC_NS = 120; // Read access time
  localparam int T_CEH_NS = 50; // Chip select high between reads, least
  localparam int T_OEHP_NS = 150; // Output strobe high pulse while polling, least
  localparam int T_WC_MS = 10; // Internal write period, longest
  // Least times round up to whole cycles
  localparam logic [CNT_W-1:0] WP_CYC = CNT_W'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] WPH_CYC = CNT_W'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] AH_CYC = CNT_W'((T_AH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ACC_CYC = CNT_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RGAP_CYC =
    CNT_W'(((T_OEHP_NS > T_CEH_NS ? T_OEHP_NS : T_CEH_NS) + CLK_NS - 1) / CLK_NS);
  // Poll timeout: write period in cycles, used as a top parameter default
  localparam int WC_CYC = T_WC_MS * 1000000 / CLK_NS;
  // Requested protection action
  typedef enum logic [1:0] {
    EEW_PROT_NONE = 2'b00,
    EEW_PROT_ON = 2'b01,
    EEW_PROT_OFF = 2'b10
  } eew_prot_t;
  // Bus cycle engine states
  typedef enum logic [2:0] {
    EEW_CY_IDLE = 3'b000,
    EEW_CY_WSET = 3'b001,
    EEW_CY_WLOW = 3'b010,
    EEW_CY_WHOLD = 3'b011,
    EEW_CY_RACC = 3'b100,
    EEW_CY_GAP = 3'b101
  } eew_cy_t;
  // Sequencer states
  typedef enum logic [2:0] {
    EEW_ST_IDLE = 3'b000,
    EEW_ST_CMD = 3'b001,
    EEW_ST_LOAD = 3'b010,
    EEW_ST_LWAIT = 3'b011,
    EEW_ST_POLL = 3'b100,
    EEW_ST_DONE = 3'b101
  } eew_st_t;
endpackage : eew_pkg

// ### design/eew_cyc_if.sv
// Request channel between the sequencer and the bus cycle engine.
// Assumes both ends run on the same clock; req is a one-cycle pulse.
`timescale 1ns/1ps
interface eew_cyc_if;
  logic req; // Start one bus cycle
  logic wr; // 1 write, 0 read
  logic [16:0] addr; // Cycle address
  logic [7:0] wdata; // Write byte
  logic done; // One-cycle pulse at end of cycle
  logic [7:0] rdata; // Read byte, valid with done
  modport ctrl (output req, wr, addr, wdata, input done, rdata);
  modport engine (input req, wr, addr, wdata, output done, rdata);
endinterface : eew_cyc_if

// ### design/eew_cycle.sv
// Bus cycle engine: turns one read or write request into strobe timing.
// Assumes the memory data pins arrive asynchronously; they pass a 3-stage synchroniser.
`timescale 1ns/1ps
module eew_cycle (
  input wire logic sys_clk,
  input wire logic reset_n,
  eew_cyc_if.engine cyc,
  output logic [16:0] mem_addr,
  output logic [7:0] mem_dout,
  output logic mem_doe,
  input wire logic [7:0] mem_din,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n
);
  import eew_pkg::*;

  eew_cy_t state, next_state; // Cycle phase
  logic [CNT_W-1:0] cnt, next_cnt; // Phase timer
  logic [7:0] din_a, din_b, din_c; // Pin synchroniser stages
  logic [16:0] next_mem_addr;
  logic [7:0] next_mem_dout, next_rdata;
  logic next_mem_doe, next_ce_n, next_oe_n, next_we_n, next_done;

  // Phase sequencing; output strobe stays high whenever write strobe is low
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_mem_addr = mem_addr;
    next_mem_dout = mem_dout;
    next_mem_doe = mem_doe;
    next_ce_n = mem_ce_n;
    next_oe_n = mem_oe_n;
    next_we_n = mem_we_n;
    next_done = 1'b0;
    next_rdata = cyc.rdata;
    case (state)
      EEW_CY_IDLE: begin
        if (cyc.req) begin
          next_mem_addr = cyc.addr;
          next_mem_dout = cyc.wdata;
          next_ce_n = 1'b0;
          if (cyc.wr) begin
            // Output strobe high before write strobe falls
            next_oe_n = 1'b1;
            next_mem_doe = 1'b1;
            next_state = EEW_CY_WSET;
          end else begin
            next_oe_n = 1'b0;
            next_cnt = ACC_CYC;
            next_state = EEW_CY_RACC;
          end
        end
      end
      EEW_CY_WSET: begin
        // One cycle of address set-up, then strobe low
        next_we_n = 1'b0;
        next_cnt = WP_CYC;
        next_state = EEW_CY_WLOW;
      end
      EEW_CY_WLOW: begin
        // Pulse covers address hold too, since hold is shorter
        if (cnt == AH_CYC || cnt > 1) begin
          next_cnt = cnt - 1'b1;
        end
        if (cnt <= 1) begin
          next_we_n = 1'b1;
          next_cnt = WPH_CYC;
          next_state = EEW_CY_WHOLD;
        end
      end
      EEW_CY_WHOLD: begin
        // Data and address held past the rising strobe
        next_ce_n = 1'b1;
        next_mem_doe = 1'b0;
        next_state = EEW_CY_GAP;
      end
      EEW_CY_RACC: begin
        // Wait access time, then take data once the last two stages agree
        if (cnt != 0) begin
          next_cnt = cnt - 1'b1;
        end else if (din_b == din_c) begin
          next_rdata = din_c;
          next_oe_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = RGAP_CYC;
          next_state = EEW_CY_GAP;
        end
      end
      EEW_CY_GAP: begin
        // Strobes high long enough for the next toggle read or write
        if (cnt > 1) begin
          next_cnt = cnt - 1'b1;
        end else begin
          // Done only once the gap is over, so a follow-on request is never lost
          next_done = 1'b1;
          next_cnt = '0;
          next_state = EEW_CY_IDLE;
        end
      end
      default: next_state = EEW_CY_IDLE;
    endcase
  end

  // Registers; strobes idle high after reset
  always_ff @(posedge sys_clk) begin
    din_a <= mem_din;
    din_b <= din_a;
    din_c <= din_b;
    if (!reset_n) begin
      state <= EEW_CY_IDLE;
      cnt <= '0;
      mem_addr <= '0;
      mem_dout <= '0;
      mem_doe <= 1'b0;
      mem_ce_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      cyc.done <= 1'b0;
      cyc.rdata <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      mem_addr <= next_mem_addr;
      mem_dout <= next_mem_dout;
      mem_doe <= next_mem_doe;
      mem_ce_n <= next_ce_n;
      mem_oe_n <= next_oe_n;
      mem_we_n <= next_we_n;
      cyc.done <= next_done;
      cyc.rdata <= next_rdata;
    end
  end
endmodule : eew_cycle

// ### design/eew_host.sv
// Host controller for a byte-wide paged memory with software write protection.
// Assumes the user side is on sys_clk and the memory pins are asynchronous.
`timescale 1ns/1ps
module eew_host #(
  parameter int WC_TMO = eew_pkg::WC_CYC, // Poll timeout, cycles
  parameter logic [14:0] CMD_ADDR [3] = '{15'h0001, 15'h0002, 15'h0003}, // Arbitrary
  parameter logic [7:0] CMD_ON [3] = '{8'h01, 8'h02, 8'h03}, // Arbitrary
  parameter logic [7:0] CMD_OFF [3] = '{8'h01, 8'h02, 8'h04} // Arbitrary
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire eew_pkg::eew_prot_t prot_mode,
  input wire logic poll_toggle,
  input wire logic [16:0] base_addr,
  input wire logic [7:0] byte_count,
  input wire logic [7:0] wdata,
  input wire logic wdata_valid,
  output logic wdata_ready,
  output logic busy,
  output logic done,
  output logic timeout_err,
  output logic [7:0] poll_data,
  output logic [16:0] mem_addr,
  output logic [7:0] mem_dout,
  output logic mem_doe,
  input wire logic [7:0] mem_din,
  output logic mem_ce_n,
  output logic mem_oe_n,
  output logic mem_we_n
);
  import eew_pkg::*;
  localparam int TMO_W = $clog2(WC_TMO + 1); // Timeout counter width

  eew_cyc_if cyc (); // Channel to the cycle engine

  eew_cycle u_cycle (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .cyc(cyc),
    .mem_addr(mem_addr),
    .mem_dout(mem_dout),
    .mem_doe(mem_doe),
    .mem_din(mem_din),
    .mem_ce_n(mem_ce_n),
    .mem_oe_n(mem_oe_n),
    .mem_we_n(mem_we_n)
  );

  eew_st_t state, next_state; // Sequencer state
  eew_prot_t prot, next_prot; // Latched action
  logic [1:0] idx, next_idx; // Command byte index
  logic [9:0] page, next_page; // Page lines, frozen per load
  logic [OFS_W-1:0] ofs, next_ofs; // Offset within page
  logic [7:0] total, next_total; // Bytes to load
  logic [7:0] loaded, next_loaded; // Bytes loaded so far
  logic [7:0] last_data, next_last_data; // Last written byte
  logic [16:0] last_addr, next_last_addr; // Poll address
  logic use_toggle, next_use_toggle; // Toggle or data polling
  logic have_prev, next_have_prev; // A previous toggle read exists
  logic prev_t, next_prev_t; // Previous toggle bit
  logic [TMO_W-1:0] tmo, next_tmo; // Poll time spent
  logic req, next_req, wr, next_wr;
  logic [16:0] caddr, next_caddr;
  logic [7:0] cdata, next_cdata;
  logic next_wdata_ready, next_busy, next_done, next_err;
  logic [7:0] next_poll_data;

  assign cyc.req = req;
  assign cyc.wr = wr;
  assign cyc.addr = caddr;
  assign cyc.wdata = cdata;

  // Command byte for a sequence step; only the low address lines matter
  function automatic logic [7:0] cmd_byte(input eew_prot_t p, input logic [1:0] i);
    cmd_byte = (p == EEW_PROT_OFF) ? CMD_OFF[i] : CMD_ON[i];
  endfunction : cmd_byte

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_prot = prot;
    next_idx = idx;
    next_page = page;
    next_ofs = ofs;
    next_total = total;
    next_loaded = loaded;
    next_last_data = last_data;
    next_last_addr = last_addr;
    next_use_toggle = use_toggle;
    next_have_prev = have_prev;
    next_prev_t = prev_t;
    next_tmo = tmo;
    next_req = 1'b0;
    next_wr = wr;
    next_caddr = caddr;
    next_cdata = cdata;
    next_wdata_ready = 1'b0;
    next_busy = busy;
    next_done = 1'b0;
    next_err = timeout_err;
    next_poll_data = poll_data;
    case (state)
      EEW_ST_IDLE: begin
        if (start) begin
          next_busy = 1'b1;
          next_err = 1'b0;
          next_prot = prot_mode;
          next_page = base_addr[16:7];
          next_ofs = base_addr[OFS_W-1:0];
          next_total = (byte_count > 8'(PAGE_BYTES)) ? 8'(PAGE_BYTES) : byte_count;
          next_loaded = '0;
          next_use_toggle = poll_toggle;
          next_idx = '0;
          if (prot_mode != EEW_PROT_NONE) begin
            // First command byte on the fifteen command lines
            next_req = 1'b1;
            next_wr = 1'b1;
            next_caddr = {2'b00, CMD_ADDR[0]};
            next_cdata = cmd_byte(prot_mode, 2'b00);
            next_state = EEW_ST_CMD;
          end else if (byte_count == 0) begin
            next_state = EEW_ST_DONE; // Nothing to write
          end else begin
            next_state = EEW_ST_LOAD;
          end
        end
      end
      EEW_ST_CMD: begin
        if (cyc.done) begin
          next_last_addr = caddr;
          next_last_data = cdata;
          if (idx == 2'(CMD_LEN - 1)) begin
            if (total == 0) begin
              // No data: timer still runs, only toggle polling is meaningful
              next_use_toggle = 1'b1;
              next_have_prev = 1'b0;
              next_tmo = '0;
              next_req = 1'b1;
              next_wr = 1'b0;
              next_state = EEW_ST_POLL;
            end else begin
              next_state = EEW_ST_LOAD;
            end
          end else begin
            next_idx = idx + 1'b1;
            next_req = 1'b1;
            next_caddr = {2'b00, CMD_ADDR[idx + 1'b1]};
            next_cdata = cmd_byte(prot, idx + 1'b1);
          end
        end
      end
      EEW_ST_LOAD: begin
        if (wdata_valid) begin
          // Page lines never change within one load
          next_wdata_ready = 1'b1;
          next_req = 1'b1;
          next_wr = 1'b1;
          next_caddr = {page, ofs};
          next_cdata = wdata;
          next_state = EEW_ST_LWAIT;
        end
      end
      EEW_ST_LWAIT: begin
        if (cyc.done) begin
          next_last_addr = caddr;
          next_last_data = cdata;
          next_ofs = ofs + 1'b1; // Wraps inside the page
          next_loaded = loaded + 1'b1;
          if (loaded + 1'b1 == total) begin
            next_have_prev = 1'b0;
            next_tmo = '0;
            next_req = 1'b1;
            next_wr = 1'b0;
            next_caddr = caddr;
            next_state = EEW_ST_POLL;
          end else begin
            next_state = EEW_ST_LOAD;
          end
        end
      end
      EEW_ST_POLL: begin
        // Each read is a full strobe pulse, so status toggles per read
        next_caddr = last_addr;
        if (tmo != TMO_W'(WC_TMO)) begin
          next_tmo = tmo + 1'b1;
        end
        if (cyc.done) begin
          next_poll_data = cyc.rdata;
          next_prev_t = cyc.rdata[6];
          next_have_prev = 1'b1;
          if (use_toggle ? (have_prev && cyc.rdata[6] == prev_t)
                         : (cyc.rdata[7] == last_data[7])) begin
            next_state = EEW_ST_DONE;
          end else if (tmo == TMO_W'(WC_TMO)) begin
            next_err = 1'b1; // Write never finished
            next_state = EEW_ST_DONE;
          end else begin
            next_req = 1'b1;
          end
        end
      end
      EEW_ST_DONE: begin
        next_done = 1'b1;
        next_busy = 1'b0;
        next_state = EEW_ST_IDLE;
      end
      default: next_state = EEW_ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= EEW_ST_IDLE;
      prot <= EEW_PROT_NONE;
      idx <= '0;
      page <= '0;
      ofs <= '0;
      total <= '0;
      loaded <= '0;
      last_data <= '0;
      last_addr <= '0;
      use_toggle <= 1'b0;
      have_prev <= 1'b0;
      prev_t <= 1'b0;
      tmo <= '0;
      req <= 1'b0;
      wr <= 1'b0;
      caddr <= '0;
      cdata <= '0;
      wdata_ready <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      timeout_err <= 1'b0;
      poll_data <= '0;
    end else begin
      state <= next_state;
      prot <= next_prot;
      idx <= next_idx;
      page <= next_page;
      ofs <= next_ofs;
      total <= next_total;
      loaded <= next_loaded;
      last_data <= next_last_data;
      last_addr <= next_last_addr;
      use_toggle <= next_use_toggle;
      have_prev <= next_have_prev;
      prev_t <= next_prev_t;
      tmo <= next_tmo;
      req <= next_req;
      wr <= next_wr;
      caddr <= next_caddr;
      cdata <= next_cdata;
      wdata_ready <= next_wdata_ready;
      busy <= next_busy;
      done <= next_done;
      timeout_err <= next_err;
      poll_data <= next_poll_data;
    end
  end
endmodule : eew_host

// ### test/eew_host_assertions.sv
// Pin checker for the protected page write host.
// Assumes it is bound into eew_host; one clock domain.
`timescale 1ns/1ps
module eew_host_assertions
  import eew_pkg::*;
#(
  parameter logic [14:0] CMD_ADDR [3] = '{15'h0001, 15'h0002, 15'h0003}, // Arbitrary
  parameter logic [7:0] CMD_ON [3] = '{8'h01, 8'h02, 8'h03}, // Arbitrary
  parameter logic [7:0] CMD_OFF [3] = '{8'h01, 8'h02, 8'h04} // Arbitrary
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic start,
  input wire eew_pkg::eew_prot_t prot_mode,
  input wire logic poll_toggle,
  input wire logic [7:0] byte_count,
  input wire logic busy,
  input wire logic done,
  input wire logic timeout_err,
  input wire logic [7:0] poll_data,
  input wire logic [16:0] mem_addr,
  input wire logic [7:0] mem_dout,
  input wire logic mem_doe,
  input wire logic mem_ce_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [16:0] rd_addr; // Address of the latest poll read
  logic rd_seen; // Poll read seen this operation
  logic tog_m; // Toggle mode latched at start
  logic [7:0] cnt_m; // Count latched at start
  logic [7:0] last_wd; // Last byte written
  // Operation context, cleared at each accepted start
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_seen <= 1'b0;
    end else if (start && !busy) begin
      rd_seen <= 1'b0;
      tog_m <= poll_toggle;
      cnt_m <= byte_count;
    end else if ($fell(mem_oe_n)) begin
      rd_seen <= 1'b1;
      rd_addr <= mem_addr;
    end
    if ($fell(mem_we_n)) last_wd <= mem_dout;
  end
  a_wr_oe_high: assert property (!mem_we_n |-> mem_oe_n && !mem_ce_n)
    else $error("output strobe low in write");
  a_rd_strobes: assert property (!mem_oe_n |-> !mem_ce_n && mem_we_n && !mem_doe)
    else $error("bad read strobes");
  a_wr_hold: assert property ($fell(mem_we_n) |->
    (!mem_we_n && mem_doe && $stable(mem_addr) && $stable(mem_dout))[*8] ##1 !mem_we_n)
    else $error("write pulse short or lines moved");
  a_rd_gap: assert property ($rose(mem_oe_n) |-> mem_oe_n[*8] ##1 mem_oe_n[*7])
    else $error("output strobe high pulse short");
  a_poll_addr: assert property ($fell(mem_oe_n) && rd_seen |-> mem_addr == rd_addr)
    else $error("poll address moved");
  a_on_first: assert property (start && !busy && prot_mode == EEW_PROT_ON |->
    ##[1:40] ($fell(mem_we_n) && mem_addr == {2'b00, CMD_ADDR[0]} && mem_dout == CMD_ON[0]))
    else $error("enable sequence first byte wrong");
  a_off_third: assert property (start && !busy && prot_mode == EEW_PROT_OFF |->
    ##[1:150] ($fell(mem_we_n) && mem_addr == {2'b00, CMD_ADDR[2]} && mem_dout == CMD_OFF[2]))
    else $error("disable sequence third byte wrong");
  a_data_done: assert property ((done && !tog_m && cnt_m != 8'h00) ##1 !timeout_err |->
    $past(poll_data[7]) == $past(last_wd[7]))
    else $error("data poll ended on wrong bit");
  c_prot_on: cover property (start && !busy && prot_mode == EEW_PROT_ON);
  c_timeout: cover property ($rose(timeout_err));
  c_tog_done: cover property (done && tog_m);
endmodule : eew_host_assertions
bind eew_host eew_host_assertions #(.CMD_ADDR(CMD_ADDR), .CMD_ON(CMD_ON), .CMD_OFF(CMD_OFF))
  u_chk (.sys_clk(sys_clk), .reset_n(reset_n), .start(start), .prot_mode(prot_mode),
  .poll_toggle(poll_toggle), .byte_count(byte_count), .busy(busy), .done(done),
  .timeout_err(timeout_err), .poll_data(poll_data), .mem_addr(mem_addr),
  .mem_dout(mem_dout), .mem_doe(mem_doe), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n),
  .mem_we_n(mem_we_n));

// ### test/eew_mem_model.sv
// Behavioural paged memory: command detect, write timer, status polling.
// Assumes host strobes move just after sys_clk edges; timer counts sys_clk.
`timescale 1ns/1ps
module eew_mem_model #(
  parameter logic [14:0] CA [3] = '{15'h0001, 15'h0002, 15'h0003}, // Arbitrary
  parameter logic [7:0] CON [3] = '{8'h01, 8'h02, 8'h03}, // Arbitrary
  parameter logic [7:0] COFF [3] = '{8'h01, 8'h02, 8'h04} // Arbitrary
) (
  input wire logic sys_clk,
  input wire logic [16:0] addr,
  input wire logic [7:0] din,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input int wt,
  output logic [7:0] dout
);
  logic [7:0] mem [int]; // Stored bytes, erased reads ff
  logic [7:0] pbuf [int]; // Page latches
  logic prot = 1'b0; // Write protected
  logic p_on = 1'b0, p_off = 1'b0, allow = 1'b0;
  logic busy_w = 1'b0; // Internal write running
  logic bad_page = 1'b0; // Page lines moved within a load
  logic tog = 1'b0; // Toggle bit, start state left as is
  logic pwe = 1'b1, prd = 1'b1;
  logic [7:0] last_wr = 8'h00, rd = 8'h00, hold = 8'h00;
  int k = 0, cnt = 0, pg = -1;
  // Released bus shows the inverse, so a stale sample never matches
  assign dout = (!ce_n && !oe_n && we_n) ? rd : ~hold;
  always @(posedge sys_clk) begin
    pwe <= we_n;
    prd <= ce_n | oe_n;
    if (!ce_n && !oe_n) hold <= rd;
    if (!pwe && we_n && !ce_n) begin
      cnt <= 1;
      busy_w <= 1'b1;
      last_wr <= din;
      if (k < 3 && addr[14:0] == CA[k] && (din == CON[k] || din == COFF[k])) begin
        k <= k + 1;
        if (k == 2) begin
          p_on <= din == CON[2];
          p_off <= din == COFF[2];
          allow <= 1'b1;
        end
      end else begin
        if (!prot || allow) pbuf[int'(addr)] = din;
        if (pg < 0) pg = int'(addr[16:7]);
        else if (pg != int'(addr[16:7])) bad_page <= 1'b1;
      end
    end else if (busy_w && cnt >= wt) begin
      foreach (pbuf[j]) mem[j] = pbuf[j];
      pbuf.delete();
      if (p_on || p_off) prot <= p_on;
      k <= 0;
      p_on <= 1'b0;
      p_off <= 1'b0;
      allow <= 1'b0;
      pg = -1;
      busy_w <= 1'b0;
    end else if (busy_w) cnt <= cnt + 1;
    // The later of the two strobes falling starts a status read
    if (prd && !(ce_n | oe_n) && we_n) begin
      tog <= ~tog;
      if (busy_w) rd <= {~last_wr[7], tog, last_wr[5:0]};
      else rd <= mem.exists(int'(addr)) ? mem[int'(addr)] : 8'hff;
    end
  end
endmodule : eew_mem_model

// ### test/eew_host_bench.sv
// Self-checking bench for eew_host against the memory model.
// Assumes the design package and interface are compiled first.
`timescale 1ns/1ps
module eew_host_bench;
  import eew_pkg::*;
  localparam int TMO = 2000; // Short poll timeout for simulation
  logic sys_clk = 1'b0, reset_n = 1'b0, start = 1'b0, poll_toggle = 1'b0, wdata_valid = 1'b0;
  eew_prot_t prot_mode = EEW_PROT_NONE;
  logic [16:0] base_addr = 17'h00000, mem_addr;
  logic [7:0] byte_count = 8'h00, wdata = 8'h00, poll_data, mem_dout, mem_din;
  logic wdata_ready, busy, done, timeout_err, mem_doe, mem_ce_n, mem_oe_n, mem_we_n;
  int seed = 32'hbded, bad_count = 0, compares = 0, wt = 100, widx = 0, t, r;
  logic exp_prot = 1'b0; // Protection expected in the model
  logic [7:0] bytes [128]; // Bytes of the current load
  // Corner cases: mode, toggle, count, write time, timeout
  eew_prot_t c_m [7] = '{EEW_PROT_NONE, EEW_PROT_ON, EEW_PROT_NONE, EEW_PROT_OFF,
    EEW_PROT_ON, EEW_PROT_OFF, EEW_PROT_NONE};
  logic c_t [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int c_n [7] = '{77, 0, 5, 128, 1, 200, 1};
  int c_w [7] = '{100, 300, 200, 50, 1500, 400, 3000};
  logic c_o [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  always #5 sys_clk = ~sys_clk;
  eew_host #(.WC_TMO(TMO)) DUT (.sys_clk(sys_clk), .reset_n(reset_n), .start(start),
    .prot_mode(prot_mode), .poll_toggle(poll_toggle), .base_addr(base_addr),
    .byte_count(byte_count), .wdata(wdata), .wdata_valid(wdata_valid),
    .wdata_ready(wdata_ready), .busy(busy), .done(done), .timeout_err(timeout_err),
    .poll_data(poll_data), .mem_addr(mem_addr), .mem_dout(mem_dout), .mem_doe(mem_doe),
    .mem_din(mem_din), .mem_ce_n(mem_ce_n), .mem_oe_n(mem_oe_n), .mem_we_n(mem_we_n));
  eew_mem_model u_mem (.sys_clk(sys_clk), .addr(mem_addr), .din(mem_dout), .ce_n(mem_ce_n),
    .oe_n(mem_oe_n), .we_n(mem_we_n), .wt(wt), .dout(mem_din));
  // Next byte once the previous one is taken
  always @(posedge sys_clk) begin
    if (wdata_ready === 1'b1) begin
      widx <= widx + 1;
      wdata <= bytes[(widx + 1) % 128];
    end
  end
  function automatic logic [16:0] waddr(input logic [16:0] a, input int i);
    return {a[16:7], a[6:0] + 7'(i)}; // Offset wraps inside the page
  endfunction : waddr
  function automatic logic [7:0] peek(input logic [16:0] a);
    return u_mem.mem.exists(int'(a)) ? u_mem.mem[int'(a)] : 8'hff;
  endfunction : peek
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1
  task automatic give_verdict;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  // One operation, then check flags, protection and stored bytes
  task automatic run_op(input eew_prot_t m, input logic tg, input int n, input int w,
    input logic to);
    logic [16:0] a;
    logic [7:0] old [128];
    logic ok;
    int i;
    int k;
    a = 17'($random(seed));
    a[13] = 1'b1; // Keeps data clear of command addresses
    ok = (m != EEW_PROT_NONE) || !exp_prot;
    for (i = 0; i < 128; i++) begin
      bytes[i] = 8'($random(seed));
      old[i] = peek(waddr(a, i));
    end
    wt = w;
    @(posedge sys_clk);
    start <= 1'b1;
    prot_mode <= m;
    poll_toggle <= tg;
    base_addr <= a;
    byte_count <= 8'(n);
    widx <= 0;
    wdata <= bytes[0];
    wdata_valid <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 20000);
    if (k >= 20000) begin
      bad_count++;
      give_verdict();
    end
    cmp1(timeout_err, to);
    cmp1(busy, 1'b0);
    if (!to) cmp1(u_mem.busy_w, 1'b0);
    cmp1(u_mem.bad_page, 1'b0);
    k = 0;
    while (u_mem.busy_w === 1'b1 && k < 5000) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (!to && n > 0) cmp8(poll_data, peek(waddr(a, (n > 128 ? 128 : n) - 1)));
    if (m == EEW_PROT_ON) exp_prot = 1'b1;
    if (m == EEW_PROT_OFF) exp_prot = 1'b0;
    cmp1(u_mem.prot, exp_prot);
    for (i = 0; i < 128; i++) cmp8(peek(waddr(a, i)), (ok && i < n) ? bytes[i] : old[i]);
  endtask : run_op
  // Reset, corner table, then random traffic
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (t = 0; t < 7; t++) begin
      run_op(c_m[t], c_t[t], c_n[t], c_w[t], c_o[t]);
      $display("test %0d done", t);
    end
    for (t = 7; t < 13; t++) begin
      r = $random(seed);
      run_op(eew_prot_t'(exp_prot ? 2'(1 + (r & 1)) : 2'($unsigned(r) % 3)), r[4],
        1 + (r >>> 8 & 127),
        50 + (r >>> 16 & 511), 1'b0);
      $display("test %0d done", t);
    end
    give_verdict();
  end
endmodule : eew_host_bench
